// *** verilog/fldps_pkg.sv ***
package fldps_pkg;

	// register map (byte addresses, printed offset is an index)
	localparam logic [7:0] FLDPS_IDX_LINK_LINE_CONTROL = 8'h0B;
	localparam logic [7:0] FLDPS_ADDR_LINK_LINE_CONTROL = 8'h2C;
	localparam logic [7:0] FLDPS_ADDR_DROP_STATUS = 8'h40;
	localparam logic [7:0] FLDPS_ADDR_DROP_CLEAR = 8'h44;
	localparam logic [7:0] FLDPS_ADDR_DROP_ENABLE = 8'h48;

	// link_line_control field positions
	localparam int FLDPS_BIT_POLARITY = 6;
	localparam int FLDPS_BIT_PAIR_SWAP = 5;
	localparam int FLDPS_BIT_RSVD_RW = 4;
	localparam int FLDPS_BIT_RXERR_EN = 3;
	localparam int FLDPS_BIT_MLT3_EN = 2;
	localparam int FLDPS_BIT_SNR_EN = 1;
	localparam int FLDPS_BIT_ENERGY_EN = 0;
	localparam logic [6:0] FLDPS_CTRL_RESET = 7'h00;
	localparam logic [15:0] FLDPS_CTRL_RW_MASK = 16'h007F;
	localparam logic [3:0] FLDPS_IRQ_RESET = 4'h0;

	// monitor thresholds and window timing
	localparam int FLDPS_RXERR_LIMIT = 32;
	localparam int FLDPS_MLT3_LIMIT = 20;
	localparam int FLDPS_SNR_LIMIT = 20;
	localparam int FLDPS_CLK_PERIOD_NS = 10;
	localparam int FLDPS_WINDOW_NS = 10000;
	localparam int FLDPS_WINDOW_CYCLES = FLDPS_WINDOW_NS / FLDPS_CLK_PERIOD_NS;

	// line-side steering bundle
	typedef struct packed {
		logic tx_invert;
		logic rx_invert;
		logic pair_swap;
		logic mirror;
	} fldps_line_s;

	// raw monitor event bundle
	typedef struct packed {
		logic rx_error;
		logic mlt3_violation;
		logic snr_crossing;
		logic energy_loss;
	} fldps_event_s;

endpackage : fldps_pkg

// *** verilog/fldps_window_counter.sv ***
`timescale 1ns/1ps
module fldps_window_counter import fldps_pkg::*; #(
	parameter int LIMIT = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic window_start,
	input wire logic event_in,
	output logic hit
);
	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LIM = CW'(LIMIT);

	logic [CW-1:0] count_ff;

	// count restarts on each window edge so nothing carries over
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_ff <= '0;
		end else if (!enable || window_start) begin
			count_ff <= (enable && event_in) ? CW'(1) : '0;
		end else if (event_in && count_ff != LIM) begin
			count_ff <= count_ff + CW'(1);
		end
	end

	assign hit = enable && (count_ff == LIM);

endmodule : fldps_window_counter

// *** verilog/fldps_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// - control bits 15 to 7 ignore writes and always read back as zero.
// - polarity bit 6 high keeps normal polarity, low inverts both pairs.
// - pair-swap bit 5 high receives on the transmit-named pair and transmits on the other.
// - mirroring is active only while bits 5 and 6 are both high.
// - bit 3 drops the link after 32 receive errors within one 10 us window.
// - bit 2 drops the link after 20 MLT3 coding violations within one 10 us window.
// - bit 1 drops the link after 20 low-SNR crossings within one 10 us window.
// - bit 0 drops the link when the energy detector reports energy loss.
// - the link-drop request is the OR of the four enabled monitor conditions.
// - bit 4 is a plain read-write bit reset to zero with no effect.
module fldps_ctrl import fldps_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire fldps_event_s events_in,
	output fldps_line_s line_ctrl,
	output logic link_drop,
	output logic irq
);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int WCW = $clog2(FLDPS_WINDOW_CYCLES);
	localparam logic [WCW-1:0] WIN_LAST = WCW'(FLDPS_WINDOW_CYCLES - 1);

	logic [6:0] ctrl_ff;
	logic [3:0] status_ff;
	logic [3:0] irq_en_ff;
	logic [3:0] ev_meta_ff;
	logic [3:0] ev_sync_ff;
	logic [WCW-1:0] win_ff;
	logic win_start;
	logic [3:0] hits;
	logic nxt_drop;
	logic [7:0] aw_addr_ff;
	logic aw_have_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic w_have_ff;
	logic do_write;
	logic [31:0] nxt_rdata;
	logic [1:0] nxt_rresp;
	logic ctrl_wr;
	logic clr_wr;
	fldps_event_s ev;

	// event pins come from analog/dsp logic outside this domain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_meta_ff <= 4'h0;
			ev_sync_ff <= 4'h0;
		end else begin
			ev_meta_ff <= events_in;
			ev_sync_ff <= ev_meta_ff;
		end
	end
	assign ev = fldps_event_s'(ev_sync_ff);

	// free-running 10 us window timer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			win_ff <= '0;
		end else if (win_ff == WIN_LAST) begin
			win_ff <= '0;
		end else begin
			win_ff <= win_ff + WCW'(1);
		end
	end
	assign win_start = (win_ff == WIN_LAST);

	// receive error monitor
	fldps_window_counter #(
		.LIMIT(FLDPS_RXERR_LIMIT)
	) u_rxerr (
		.clk(clk),
		.rst_n(rst_n),
		.enable(ctrl_ff[FLDPS_BIT_RXERR_EN]),
		.window_start(win_start),
		.event_in(ev.rx_error),
		.hit(hits[3])
	);

	// mlt3 violation monitor
	fldps_window_counter #(
		.LIMIT(FLDPS_MLT3_LIMIT)
	) u_mlt3 (
		.clk(clk),
		.rst_n(rst_n),
		.enable(ctrl_ff[FLDPS_BIT_MLT3_EN]),
		.window_start(win_start),
		.event_in(ev.mlt3_violation),
		.hit(hits[2])
	);

	// low snr crossing monitor
	fldps_window_counter #(
		.LIMIT(FLDPS_SNR_LIMIT)
	) u_snr (
		.clk(clk),
		.rst_n(rst_n),
		.enable(ctrl_ff[FLDPS_BIT_SNR_EN]),
		.window_start(win_start),
		.event_in(ev.snr_crossing),
		.hit(hits[1])
	);

	// energy loss needs no counting; sync delay is well inside 10 us
	assign hits[0] = ctrl_ff[FLDPS_BIT_ENERGY_EN] && ev.energy_loss;

	assign nxt_drop = |hits;

	// drop request and line steering leave from flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_drop <= 1'b0;
			// reset steering matches the control word's reset, so the lines see no step at release
			line_ctrl.tx_invert <= !FLDPS_CTRL_RESET[FLDPS_BIT_POLARITY];
			line_ctrl.rx_invert <= !FLDPS_CTRL_RESET[FLDPS_BIT_POLARITY];
			line_ctrl.pair_swap <= FLDPS_CTRL_RESET[FLDPS_BIT_PAIR_SWAP];
			line_ctrl.mirror <= FLDPS_CTRL_RESET[FLDPS_BIT_PAIR_SWAP] && FLDPS_CTRL_RESET[FLDPS_BIT_POLARITY];
		end else begin
			link_drop <= nxt_drop;
			line_ctrl.tx_invert <= !ctrl_ff[FLDPS_BIT_POLARITY];
			line_ctrl.rx_invert <= !ctrl_ff[FLDPS_BIT_POLARITY];
			line_ctrl.pair_swap <= ctrl_ff[FLDPS_BIT_PAIR_SWAP];
			line_ctrl.mirror <= ctrl_ff[FLDPS_BIT_PAIR_SWAP] && ctrl_ff[FLDPS_BIT_POLARITY];
		end
	end

	// write channel capture: address and data in either order
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_have_ff <= 1'b0;
			w_data_ff <= 32'h0;
			w_strb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (do_write) begin
				w_have_ff <= 1'b0;
			end
		end
	end
	// ready flags leave from flops; each drops when its beat is taken and
	// returns only once the write response has been accepted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
		end
	end
	assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;
	assign ctrl_wr = do_write && (aw_addr_ff[7:2] == FLDPS_ADDR_LINK_LINE_CONTROL[7:2]);
	assign clr_wr = do_write && (aw_addr_ff[7:2] == FLDPS_ADDR_DROP_CLEAR[7:2]);

	// write response; unmapped addresses answer slverr
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr_ff[7:2])
				FLDPS_ADDR_LINK_LINE_CONTROL[7:2],
				FLDPS_ADDR_DROP_CLEAR[7:2],
				FLDPS_ADDR_DROP_ENABLE[7:2]: begin
					s_axi_bresp <= RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control word: only the low seven bits exist, upper writes are dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= FLDPS_CTRL_RESET;
		end else if (ctrl_wr && w_strb_ff[0]) begin
			ctrl_ff <= w_data_ff[6:0];
		end
	end

	// interrupt enable register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_ff <= FLDPS_IRQ_RESET;
		end else if (do_write && aw_addr_ff[7:2] == FLDPS_ADDR_DROP_ENABLE[7:2] && w_strb_ff[0]) begin
			irq_en_ff <= w_data_ff[3:0];
		end
	end

	// sticky monitor hits; a new hit beats a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_ff <= FLDPS_IRQ_RESET;
		end else begin
			status_ff <= (status_ff & ~((clr_wr && w_strb_ff[0]) ? w_data_ff[3:0] : 4'h0)) | hits;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_ff & irq_en_ff);
		end
	end

	// read decode
	always_comb begin
		nxt_rdata = 32'h0;
		nxt_rresp = RESP_OKAY;
		case (s_axi_araddr[7:2])
			FLDPS_ADDR_LINK_LINE_CONTROL[7:2]: begin
				nxt_rdata = {25'h0, ctrl_ff};
			end
			FLDPS_ADDR_DROP_STATUS[7:2]: begin
				nxt_rdata = {28'h0, status_ff};
			end
			FLDPS_ADDR_DROP_ENABLE[7:2]: begin
				nxt_rdata = {28'h0, irq_en_ff};
			end
			FLDPS_ADDR_DROP_CLEAR[7:2]: begin
				nxt_rdata = 32'h0;
			end
			default: begin
				nxt_rresp = RESP_SLVERR;
			end
		endcase
	end

	// read channel: one cycle after address is taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_arready <= 1'b1;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= nxt_rdata;
			s_axi_rresp <= nxt_rresp;
			s_axi_arready <= 1'b0; // one read in flight at a time
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// checks; steering outputs trail the control word by one flop,
	// so they are compared against its value one cycle back
	chk_mirror_pair: assert property (@(posedge clk) disable iff (!rst_n)
		line_ctrl.mirror == ($past(ctrl_ff[5]) && $past(ctrl_ff[6])))
		else $error("mirror does not follow swap and polarity");
	chk_polarity_both: assert property (@(posedge clk) disable iff (!rst_n)
		(line_ctrl.tx_invert == line_ctrl.rx_invert) &&
		(line_ctrl.tx_invert == !$past(ctrl_ff[6])))
		else $error("polarity inversion wrong");
	chk_swap_follow: assert property (@(posedge clk) disable iff (!rst_n)
		line_ctrl.pair_swap == $past(ctrl_ff[5]))
		else $error("pair swap wrong");
	chk_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(s_axi_rvalid && $past(s_axi_araddr[7:2] == 6'h0B && s_axi_arready))
		|-> s_axi_rdata[31:7] == 25'h0)
		else $error("reserved bits read nonzero");
	chk_energy_drop: assert property (@(posedge clk) disable iff (!rst_n)
		(ctrl_ff[0] && ev.energy_loss) |=> link_drop)
		else $error("energy loss did not drop link");
	chk_drop_or: assert property (@(posedge clk) disable iff (!rst_n)
		link_drop == $past(|hits))
		else $error("drop is not or of hits");
	chk_no_enable: assert property (@(posedge clk) disable iff (!rst_n)
		(ctrl_ff[3:0] == 4'h0) |=> !link_drop)
		else $error("drop with no monitor enabled");
	chk_window_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		win_start |=> win_ff == '0)
		else $error("window did not restart");
	chk_rsvd_bit: assert property (@(posedge clk) disable iff (!rst_n)
		(ctrl_wr && w_strb_ff[0]) |=> ctrl_ff[4] == $past(w_data_ff[4]))
		else $error("bit 4 not read-write");
	chk_rx_threshold: assert property (@(posedge clk) disable iff (!rst_n)
		hits[3] |-> ctrl_ff[3] &&
		(!$rose(hits[3]) || $past(ev.rx_error)))
		else $error("rx error hit while disabled or without an event");
	chk_mlt3_threshold: assert property (@(posedge clk) disable iff (!rst_n)
		hits[2] |-> ctrl_ff[2] &&
		(!$rose(hits[2]) || $past(ev.mlt3_violation)))
		else $error("mlt3 hit while disabled or without an event");
	chk_snr_threshold: assert property (@(posedge clk) disable iff (!rst_n)
		hits[1] |-> ctrl_ff[1] &&
		(!$rose(hits[1]) || $past(ev.snr_crossing)))
		else $error("snr hit while disabled or without an event");
	chk_window_clear: assert property (@(posedge clk) disable iff (!rst_n)
		win_start |=> hits[3:1] == 3'h0)
		else $error("count carried across a window edge");
	chk_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		(clr_wr && w_strb_ff[0] && (hits != 4'h0)) |=> ((status_ff & $past(hits)) == $past(hits)))
		else $error("clear beat a new hit");
	cov_mirror: cover property (@(posedge clk) disable iff (!rst_n) line_ctrl.mirror);
	cov_rx_drop: cover property (@(posedge clk) disable iff (!rst_n) hits[3]);
	cov_mlt3_drop: cover property (@(posedge clk) disable iff (!rst_n) hits[2]);
	cov_irq: cover property (@(posedge clk) disable iff (!rst_n) irq);

endmodule : fldps_ctrl

// *** bench/fldps_ctrl_test.sv ***
`timescale 1ns/1ps
module fldps_ctrl_test import fldps_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, drop, irq;
	logic [1:0] bresp, rresp;
	fldps_event_s ev = '0;
	logic [3:0] strb = 4'hF;
	int cyc = 0;
	fldps_line_s line;
	int num_errors = 0;
	int checks = 0;
	logic [31:0] seed = 32'h7373351B;
	logic [33:0] expq[$];

	fldps_ctrl fldps_ctrl_i (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .events_in(ev), .line_ctrl(line), .link_drop(drop),
		.irq(irq));

	// 100 MHz clock
	always #5 clk = ~clk;

	// cycles since reset release; the block's window timer starts there too
	always @(posedge clk) begin
		if (rst_n) cyc <= cyc + 1;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	// one write; address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int i;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) break;
		end
		bready <= 0;
		chk("bresp", er, bresp);
		if (i == 50) begin
			chk("bvalid", 1, 0);
			final_report();
		end
	endtask : wr

	// one read; the expected response is queued for the monitor
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int i;
		expq.push_back(e);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) break;
		end
		rready <= 0;
		if (i == 50) begin
			chk("rvalid", 1, 0);
			final_report();
		end
	endtask : rd

	// bounded wait for link_drop to reach a level
	task automatic seek(input logic v, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge clk);
			if (drop === v) break;
		end
		chk("link_drop", v, drop);
		if (drop !== v) final_report();
	endtask : seek

	// link_drop must stay low for n cycles
	task automatic calm(input int n);
		logic bad;
		bad = 0;
		repeat (n) begin
			@(posedge clk);
			if (drop !== 1'b0) bad = 1;
		end
		chk("no_drop", 0, bad);
	endtask : calm

	// wait until the 10 us window is well under way, so a burst cannot straddle its edge
	task automatic align;
		int i;
		for (i = 0; i < FLDPS_WINDOW_CYCLES; i++) begin
			@(posedge clk);
			if (cyc % FLDPS_WINDOW_CYCLES == 100) break;
		end
	endtask : align

	// n consecutive event cycles on one monitor input
	task automatic pulse(input int k, input int n);
		repeat (n) begin
			@(posedge clk);
			ev[k] <= 1;
		end
		@(posedge clk);
		ev[k] <= 0;
	endtask : pulse

	task automatic irq_is(input logic v);
		repeat (2) @(posedge clk);
		#1 chk("irq", v, irq);
	endtask : irq_is

	// read monitor: compares each read answer with the oldest note
	always @(posedge clk) begin
		if (rvalid && rready) begin
			if (expq.size() == 0) chk("read_queue", 0, 1);
			else chk("rdata", expq.pop_front(), {rresp, rdata});
		end
	end

	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		#1 chk("line", 4'b1100, line);
		chk("drop_irq", 0, {drop, irq});
		rd(FLDPS_ADDR_LINK_LINE_CONTROL, 0);
		rd(FLDPS_ADDR_DROP_STATUS, 0);
		rd(FLDPS_ADDR_DROP_ENABLE, 0);
		$display("reset values done");
		// random words, bits 6:5 walked through every combination
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			d = {seed[31:7], i[1:0], seed[4:0]};
			wr(FLDPS_ADDR_LINK_LINE_CONTROL, d, 0);
			rd(FLDPS_ADDR_LINK_LINE_CONTROL, {2'b00, d & 32'h7F});
			repeat (2) @(posedge clk);
			#1 chk("line", {~d[6], ~d[6], d[5], d[6] & d[5]}, line);
		end
		wr(8'h10, 32'hFFFFFFFF, 2'b10);
		rd(8'h10, {2'b10, 32'h0});
		// a write with byte lane 0 off leaves the control word alone
		strb <= 4'h0;
		wr(FLDPS_ADDR_LINK_LINE_CONTROL, 32'h7F, 0);
		strb <= 4'hF;
		rd(FLDPS_ADDR_LINK_LINE_CONTROL, {2'b00, d & 32'h7F});
		$display("control word done");
		// disabled monitors must not drop the link
		wr(FLDPS_ADDR_LINK_LINE_CONTROL, 0, 0);
		for (int k = 3; k > 0; k--) pulse(k, 64);
		@(posedge clk);
		ev[0] <= 1;
		calm(50);
		ev[0] <= 0;
		wr(FLDPS_ADDR_DROP_CLEAR, 32'hF, 0);
		// each counting monitor: burst, window end, limit minus one, limit
		for (int k = 3; k > 0; k--) begin
			wr(FLDPS_ADDR_LINK_LINE_CONTROL, 32'h1 << k, 0);
			align();
			pulse(k, 64);
			seek(1, 10);
			seek(0, 1100);
			pulse(k, (k == 3) ? 31 : 19);
			calm(10);
			pulse(k, 1);
			seek(1, 10);
			seek(0, 1100);
		end
		$display("counting monitors done");
		wr(FLDPS_ADDR_LINK_LINE_CONTROL, 32'h9, 0);
		@(posedge clk);
		ev[0] <= 1;
		seek(1, 1000);
		// clearing while energy loss still holds: the new hit must win
		wr(FLDPS_ADDR_DROP_CLEAR, 32'h1, 0);
		rd(FLDPS_ADDR_DROP_STATUS, 32'hF);
		ev[0] <= 0;
		seek(0, 20);
		$display("energy monitor done");
		rd(FLDPS_ADDR_DROP_STATUS, 32'hF);
		wr(FLDPS_ADDR_DROP_ENABLE, 32'h8, 0);
		irq_is(1);
		wr(FLDPS_ADDR_DROP_ENABLE, 0, 0);
		irq_is(0);
		wr(FLDPS_ADDR_DROP_ENABLE, 32'hF, 0);
		irq_is(1);
		wr(FLDPS_ADDR_DROP_CLEAR, 32'hF, 0);
		rd(FLDPS_ADDR_DROP_STATUS, 0);
		irq_is(0);
		$display("interrupt done");
		repeat (5) @(posedge clk);
		final_report();
	end
endmodule : fldps_ctrl_test
